// file: rtl/mmbd_top.sv
// program counter, stack and data address decoder for the 8-bit core
//
// Overview of operation
// - program counter is twelve bits, covering all 4K program words.
// - after reset, fetching starts at program address zero.
// - a software interrupt sends fetch to address one.
// - every hardware interrupt sends fetch to the shared vector at eight.
// - short jump and call reach only 256 locations within the current page.
// - far jump and call load any twelve-bit address.
// - calls push the next address, interrupts the current one; any return pops it into PC.
// - the rolling-code words at 0x00E-0x00F are ordinary program space.
// - status bits 7:6 select one of four data banks.
// - the indirect port accesses bank plus low seven pointer bits.
// - direct access uses bank plus seven opcode address bits.
// - special registers 0x00-0x1F exist only in bank 0; others alias.
// - RAM at 0x20-0x7F bank 0, 0x40-0x7F others; 0x20-0x3F aliases.
// - special registers are read and written through the banked path.
// - page one registers only via the page-one write and read ops.
// - page two registers only via the page-two write and read ops.
// - page three registers only via the page-three write and read ops.
// - auxiliary page accesses ignore the bank selector.
`timescale 1ns/10ps
`default_nettype none
module mmbd_top
    import mmbd_pkg::*;
#(
    parameter int STACK_DEPTH = mmbd_pkg::STACK_DEPTH
) (
    input  wire logic                          mclk,
    input  wire logic                          reset,
    input  wire logic                          ce,
    input  wire logic                          fetch_next,
    input  wire logic                          short_jump,
    input  wire logic                          short_call,
    input  wire logic [mmbd_pkg::SHORT_W-1:0]  short_target,
    input  wire logic                          far_jump,
    input  wire logic                          far_call,
    input  wire logic [mmbd_pkg::PC_W-1:0]     far_target,
    input  wire logic                          return_plain,
    input  wire logic                          return_with_literal,
    input  wire logic                          return_from_interrupt,
    input  wire logic                          soft_int,
    input  wire logic                          hard_int,
    input  wire logic                          dm_rd,
    input  wire logic                          dm_wr,
    input  wire logic [mmbd_pkg::DADDR_W-1:0]  dm_addr,
    input  wire logic [7:0]                    dm_wdata,
    input  wire logic                          aux_rd,
    input  wire logic                          aux_wr,
    input  wire mmbd_pkg::mmbd_aux_e           aux_page,
    input  wire logic [mmbd_pkg::AUX_W-1:0]    aux_addr,
    output logic      [mmbd_pkg::PC_W-1:0]     pc,
    output logic      [mmbd_pkg::BANK_W-1:0]   bank_selector,
    output logic                               phys_rd,
    output logic                               phys_wr,
    output logic                               phys_sfr,
    output logic      [mmbd_pkg::BANK_W-1:0]   phys_bank,
    output logic      [mmbd_pkg::DADDR_W-1:0]  phys_addr,
    output logic      [7:0]                    phys_wdata,
    output logic                               own_hit,
    output logic      [7:0]                    own_rdata,
    output logic                               aux_rd_out,
    output logic                               aux_wr_out,
    output mmbd_pkg::mmbd_aux_e                aux_page_out,
    output logic      [mmbd_pkg::AUX_W-1:0]    aux_addr_out,
    output logic                               aux_unassigned
);

    // ***********************************************
    // elaboration check
    // ***********************************************
    if (PC_W != 12 || SHORT_W != 8 || (1 << SHORT_W) != SHORT_SPAN) begin : g_bad
        $error("program counter or short target width not supported");
    end

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        logic [PC_W-1:0]    pc;
        logic [7:0]         status;
        logic [7:0]         fsp;
        logic [7:0]         program_counter_high_buffer;
        logic               phys_rd;
        logic               phys_wr;
        logic               phys_sfr;
        logic [BANK_W-1:0]  phys_bank;
        logic [DADDR_W-1:0] phys_addr;
        logic [7:0]         phys_wdata;
        logic               own_hit;
        logic [7:0]         own_rdata;
        logic               aux_rd;
        logic               aux_wr;
        mmbd_aux_e          aux_page;
        logic [AUX_W-1:0]   aux_addr;
        logic               aux_unassigned;
    } mmbd_top_s;

    mmbd_top_s s_q;
    mmbd_top_s s_d;

    // ***********************************************
    // helpers
    // ***********************************************
    logic [PC_W-1:0]    stack_top;
    logic               push;
    logic               pop;
    logic [PC_W-1:0]    push_data;
    logic [BANK_W-1:0]  bank;
    logic [DADDR_W-1:0] eff_addr;
    logic               indirect;
    logic               map_sfr;
    logic [BANK_W-1:0]  map_bank;
    logic [DADDR_W-1:0] map_addr;
    logic [31:0]        aux_map;
    logic               aux_present;
    logic               any_return;
    logic [PC_W-1:0]    pc_inc;

    // bank selector from status bits 7:6
    assign bank = s_q.status[BANK_MSB:BANK_LSB];

    // indirect access takes the low seven pointer bits
    assign indirect = (dm_rd || dm_wr) && (dm_addr == ADDR_INDIRECT);
    assign eff_addr = indirect ? s_q.fsp[DADDR_W-1:0] : dm_addr;

    assign any_return = return_plain || return_with_literal || return_from_interrupt;
    assign pc_inc     = s_q.pc + PC_ONE;

    // ***********************************************
    // submodules
    // ***********************************************
    mmbd_data_map u_map (
        .bank      (bank),
        .addr      (eff_addr),
        .is_sfr    (map_sfr),
        .phys_bank (map_bank),
        .phys_addr (map_addr)
    );

    mmbd_stack #(
        .DEPTH (STACK_DEPTH),
        .W     (PC_W)
    ) u_stack (
        .mclk      (mclk),
        .reset     (reset),
        .ce        (ce),
        .push      (push),
        .pop       (pop),
        .push_data (push_data),
        .top       (stack_top)
    );

    // stack control, interrupts push the not yet executed address
    always_comb begin
        push      = 1'b0;
        pop       = 1'b0;
        push_data = pc_inc;
        if (hard_int || soft_int) begin
            push      = 1'b1;
            push_data = s_q.pc;
        end else if (far_call || short_call) begin
            push = 1'b1; // next address on top
        end else if (any_return) begin
            pop = 1'b1;
        end
    end

    // assigned address map of the selected auxiliary page
    always_comb begin
        case (aux_page)
            AUX_ONE:   aux_map = AUX_ONE_MAP;
            AUX_TWO:   aux_map = AUX_TWO_MAP;
            AUX_THREE: aux_map = AUX_THREE_MAP;
            default:   aux_map = '0;
        endcase
    end
    assign aux_present = aux_map[aux_addr];

    // ***********************************************
    // next state
    // ***********************************************
    always_comb begin
        s_d = s_q;

        // program counter, interrupts first, then jumps
        if (hard_int) begin
            s_d.pc = VEC_HARD;
        end else if (soft_int) begin
            s_d.pc = VEC_SOFT;
        end else if (far_jump || far_call) begin
            s_d.pc = far_target;
        end else if (short_jump || short_call) begin
            s_d.pc = {s_q.pc[PC_W-1:SHORT_W], short_target};
        end else if (any_return) begin
            s_d.pc = stack_top;
        end else if (dm_wr && map_sfr && map_addr == ADDR_PCL) begin
            s_d.pc = {s_q.program_counter_high_buffer[PCH_W-1:0], dm_wdata};
        end else if (fetch_next) begin
            s_d.pc = pc_inc; // rolling-code words fetch like any other
        end

        // banked data path, registered one cycle
        s_d.phys_rd    = dm_rd;
        s_d.phys_wr    = dm_wr;
        s_d.phys_sfr   = map_sfr;
        s_d.phys_bank  = map_bank;
        s_d.phys_addr  = map_addr;
        s_d.phys_wdata = dm_wdata;
        s_d.own_hit    = 1'b0;
        s_d.own_rdata  = '0;

        // own special registers on the banked path, only on a request
        if (map_sfr && (dm_rd || dm_wr)) begin
            if (map_addr == ADDR_STATUS) begin
                s_d.own_hit   = 1'b1;
                s_d.own_rdata = s_q.status;
                if (dm_wr) begin
                    s_d.status = dm_wdata;
                end
            end else if (map_addr == ADDR_FSP) begin
                s_d.own_hit   = 1'b1;
                s_d.own_rdata = s_q.fsp;
                if (dm_wr) begin
                    s_d.fsp = dm_wdata;
                end
            end else if (map_addr == ADDR_PROGRAM_COUNTER_HIGH_BUFFER) begin
                s_d.own_hit   = 1'b1;
                s_d.own_rdata = s_q.program_counter_high_buffer;
                if (dm_wr) begin
                    s_d.program_counter_high_buffer = dm_wdata;
                end
            end else if (map_addr == ADDR_PCL) begin
                s_d.own_hit   = 1'b1;
                s_d.own_rdata = s_q.pc[7:0];
            end else if (map_addr == ADDR_INDIRECT) begin
                s_d.own_hit   = 1'b1; // pointer at itself reads zero
                s_d.own_rdata = '0;
                s_d.phys_wr   = 1'b0;
            end
        end

        // auxiliary pages, reached only by their own ops
        s_d.aux_page       = aux_page;   // bank bits not used
        s_d.aux_addr       = aux_addr;
        s_d.aux_rd         = aux_rd && aux_present;
        s_d.aux_wr         = aux_wr && aux_present;
        s_d.aux_unassigned = (aux_rd || aux_wr) && !aux_present;
    end

    // ***********************************************
    // state register
    // ***********************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q          <= '0;
            s_q.pc       <= PC_RESET;
            s_q.status   <= STATUS_RESET;
            s_q.fsp      <= FSP_RESET;
            s_q.program_counter_high_buffer   <= PROGRAM_COUNTER_HIGH_BUFFER_RESET;
            s_q.aux_page <= AUX_ONE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    assign pc             = s_q.pc;
    assign bank_selector  = s_q.status[BANK_MSB:BANK_LSB];
    assign phys_rd        = s_q.phys_rd;
    assign phys_wr        = s_q.phys_wr;
    assign phys_sfr       = s_q.phys_sfr;
    assign phys_bank      = s_q.phys_bank;
    assign phys_addr      = s_q.phys_addr;
    assign phys_wdata     = s_q.phys_wdata;
    assign own_hit        = s_q.own_hit;
    assign own_rdata      = s_q.own_rdata;
    assign aux_rd_out     = s_q.aux_rd;
    assign aux_wr_out     = s_q.aux_wr;
    assign aux_page_out   = s_q.aux_page;
    assign aux_addr_out   = s_q.aux_addr;
    assign aux_unassigned = s_q.aux_unassigned;

endmodule
`default_nettype wire

// file: rtl/mmbd_pkg.sv
// constants and types shared by the memory map and bank decoder
package mmbd_pkg;

    // ***********************************************
    // program space
    // ***********************************************
    localparam int          PC_W        = 12;
    localparam int          SHORT_W     = 8;
    localparam int          SHORT_SPAN  = 256;
    localparam logic [11:0] PC_RESET    = 12'h000;
    localparam logic [11:0] VEC_SOFT    = 12'h001;
    localparam logic [11:0] VEC_HARD    = 12'h008;
    localparam logic [11:0] ROLL_LO     = 12'h00e;
    localparam logic [11:0] ROLL_HI     = 12'h00f;
    localparam logic [11:0] RSVD_LO     = 12'hffe;
    localparam logic [11:0] RSVD_HI     = 12'hfff;
    localparam logic [11:0] PC_ONE      = 12'h001;
    localparam int          STACK_DEPTH = 8;

    // ***********************************************
    // banked data space
    // ***********************************************
    localparam int         DADDR_W      = 7;
    localparam int         BANK_W       = 2;
    localparam int         BANK_MSB     = 7;
    localparam int         BANK_LSB     = 6;
    localparam int         PCH_W        = 4;
    localparam logic [6:0] SFR_LAST     = 7'h1f;
    localparam logic [6:0] SHARED_LAST  = 7'h3f;
    localparam logic [1:0] BANK_ZERO    = 2'h0;
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [6:0] ADDR_PCL     = 7'h02;
    localparam logic [6:0] ADDR_STATUS  = 7'h03;
    localparam logic [6:0] ADDR_FSP     = 7'h04;
    localparam logic [6:0] ADDR_PROGRAM_COUNTER_HIGH_BUFFER  = 7'h0a;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] FSP_RESET    = 8'h00;
    localparam logic [7:0] PROGRAM_COUNTER_HIGH_BUFFER_RESET = 8'h00;

    // ***********************************************
    // auxiliary register pages
    // ***********************************************
    localparam int          AUX_W       = 5;
    localparam logic [31:0] AUX_ONE_MAP   = 32'h0000fee0;
    localparam logic [31:0] AUX_TWO_MAP   = 32'h03ea95ff;
    localparam logic [31:0] AUX_THREE_MAP = 32'h9fb7ffff;

    typedef enum logic [1:0] {
        AUX_ONE,
        AUX_TWO,
        AUX_THREE
    } mmbd_aux_e;

endpackage

// file: rtl/mmbd_stack.sv
// return address stack for calls and interrupt entry
`timescale 1ns/10ps
`default_nettype none
module mmbd_stack #(
    parameter int DEPTH = 8,
    parameter int W     = 12
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] push_data,
    output logic      [W-1:0] top
);
    localparam int PW = $clog2(DEPTH);

    // ***********************************************
    // elaboration check
    // ***********************************************
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad
        $error("stack depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           ptr;
    } mmbd_stack_s;

    mmbd_stack_s s_q;
    mmbd_stack_s s_d;

    // circular stack, overflow overwrites the oldest entry
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.ptr          = s_q.ptr + PW'(1);
            s_d.mem[s_d.ptr] = push_data;
        end else if (pop) begin
            s_d.ptr = s_q.ptr - PW'(1);
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign top = s_q.mem[s_q.ptr];
endmodule
`default_nettype wire

// file: rtl/mmbd_data_map.sv
// folds a banked data address onto its physical location
`timescale 1ns/10ps
`default_nettype none
module mmbd_data_map
    import mmbd_pkg::*;
(
    input  wire logic [mmbd_pkg::BANK_W-1:0]  bank,
    input  wire logic [mmbd_pkg::DADDR_W-1:0] addr,
    output logic                              is_sfr,
    output logic      [mmbd_pkg::BANK_W-1:0]  phys_bank,
    output logic      [mmbd_pkg::DADDR_W-1:0] phys_addr
);
    // ***********************************************
    // bank folding
    // ***********************************************
    always_comb begin
        phys_addr = addr;
        if (addr <= SFR_LAST) begin
            is_sfr    = 1'b1; // sfr window only in bank 0
            phys_bank = BANK_ZERO;
        end else if (addr <= SHARED_LAST) begin
            is_sfr    = 1'b0; // shared ram aliases bank 0
            phys_bank = BANK_ZERO;
        end else begin
            is_sfr    = 1'b0; // banked ram
            phys_bank = bank;
        end
    end
endmodule
`default_nettype wire

// file: dv/mmbd_top_asserts.sv
// concurrent checks on the decoder top ports
`timescale 1ns/10ps
`default_nettype none
module mmbd_top_asserts
    import mmbd_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  reset,
    input wire logic                  ce,
    input wire logic                  short_jump,
    input wire logic                  short_call,
    input wire logic [7:0]            short_target,
    input wire logic                  far_jump,
    input wire logic                  far_call,
    input wire logic [11:0]           far_target,
    input wire logic                  return_plain,
    input wire logic                  soft_int,
    input wire logic                  hard_int,
    input wire logic                  dm_rd,
    input wire logic                  dm_wr,
    input wire logic [6:0]            dm_addr,
    input wire logic [7:0]            dm_wdata,
    input wire logic                  aux_rd,
    input wire mmbd_pkg::mmbd_aux_e   aux_page,
    input wire logic [4:0]            aux_addr,
    input wire logic [11:0]           pc,
    input wire logic [1:0]            bank_selector,
    input wire logic                  phys_sfr,
    input wire logic [1:0]            phys_bank,
    input wire logic [6:0]            phys_addr,
    input wire logic                  aux_rd_out,
    input wire logic                  aux_unassigned
);
    import mmbd_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // helper terms for priority and page maps
    wire ints = hard_int | soft_int;
    wire jmps = ints | far_jump | far_call | short_jump | short_call;
    wire hit  = (aux_page == AUX_ONE) ? AUX_ONE_MAP[aux_addr] :
                (aux_page == AUX_TWO) ? AUX_TWO_MAP[aux_addr] : AUX_THREE_MAP[aux_addr];
    sequence call_s;
        ce && far_call && !ints;
    endsequence
    sequence ret_s;
        ce && return_plain && !jmps;
    endsequence
    reset_vec_a: assert property ($past(reset) |-> pc == PC_RESET)
        else $error("pc not at reset vector");
    hard_vec_a: assert property (ce && hard_int |=> pc == VEC_HARD)
        else $error("pc not at hardware vector");
    soft_vec_a: assert property (ce && soft_int && !hard_int |=> pc == VEC_SOFT)
        else $error("pc not at software vector");
    far_load_a: assert property (ce && far_jump && !ints |=> pc == $past(far_target))
        else $error("far target not loaded");
    short_page_a: assert property (ce && (short_jump || short_call) && !ints && !far_jump && !far_call
        |=> pc == {$past(pc[11:8]), $past(short_target)})
        else $error("short target outside page");
    call_return_a: assert property (call_s ##1 ret_s |=> pc == $past(pc, 2) + PC_ONE)
        else $error("return address wrong");
    bank_follow_a: assert property (ce && dm_wr && dm_addr == ADDR_STATUS
        |=> bank_selector == $past(dm_wdata[7:6]))
        else $error("bank selector not from status");
    sfr_fold_a: assert property (ce && dm_rd && dm_addr != ADDR_INDIRECT && dm_addr <= SFR_LAST
        |=> phys_sfr && phys_bank == BANK_ZERO && phys_addr == $past(dm_addr))
        else $error("special register not folded");
    ram_alias_a: assert property (ce && dm_rd && dm_addr > SFR_LAST && dm_addr <= SHARED_LAST
        |=> !phys_sfr && phys_bank == BANK_ZERO)
        else $error("shared ram not aliased");
    ram_banked_a: assert property (ce && dm_rd && dm_addr > SHARED_LAST
        |=> phys_bank == $past(bank_selector) && phys_addr == $past(dm_addr))
        else $error("banked ram address wrong");
    aux_map_a: assert property (ce && aux_rd |=> aux_rd_out == $past(hit) && aux_unassigned == !$past(hit))
        else $error("aux page map wrong");
endmodule
bind mmbd_top mmbd_top_asserts u_chk (
    .mclk(mclk), .reset(reset), .ce(ce), .short_jump(short_jump), .short_call(short_call),
    .short_target(short_target), .far_jump(far_jump), .far_call(far_call), .far_target(far_target),
    .return_plain(return_plain), .soft_int(soft_int), .hard_int(hard_int), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .aux_rd(aux_rd), .aux_page(aux_page), .aux_addr(aux_addr),
    .pc(pc), .bank_selector(bank_selector), .phys_sfr(phys_sfr), .phys_bank(phys_bank),
    .phys_addr(phys_addr), .aux_rd_out(aux_rd_out), .aux_unassigned(aux_unassigned)
);
`default_nettype wire

// file: dv/mmbd_core_model.sv
// core decode model issuing one request per cycle
`timescale 1ns/10ps
`default_nettype none
module mmbd_core_model
    import mmbd_pkg::*;
(
    input  wire logic                mclk,
    output var  logic                ce,
    output var  logic [9:0]          ctl,
    output var  logic [7:0]          short_target,
    output var  logic [11:0]         far_target,
    output var  logic                dm_rd,
    output var  logic                dm_wr,
    output var  logic [6:0]          dm_addr,
    output var  logic [7:0]          dm_wdata,
    output var  logic                aux_rd,
    output var  logic                aux_wr,
    output var  mmbd_pkg::mmbd_aux_e aux_page,
    output var  logic [4:0]          aux_addr
);
    import mmbd_pkg::*;
    // idle values from time zero
    initial begin
        ce = 1'b1;
        {ctl, short_target, far_target} = '0;
        {dm_rd, dm_wr, dm_addr, dm_wdata, aux_rd, aux_wr, aux_addr} = '0;
        aux_page = AUX_ONE;
    end
    // control word, held until the next call replaces it
    task automatic op(input logic [9:0] k, input logic [11:0] ft, input logic [7:0] st);
        ctl = k;
        far_target = (ft >= RSVD_LO) ? PC_RESET : ft;
        short_target = st;
        @(posedge mclk);
        #1;
    endtask
    // banked data access
    task automatic dm(input logic rd, input logic wr, input logic [6:0] a, input logic [7:0] d);
        {dm_rd, dm_wr, dm_addr, dm_wdata} = {rd, wr, a, d};
        @(posedge mclk);
        #1;
    endtask
    // auxiliary page access
    task automatic aux(input logic rd, input logic wr, input mmbd_aux_e p, input logic [4:0] a);
        {aux_rd, aux_wr, aux_page, aux_addr} = {rd, wr, p, a};
        @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the memory map and bank decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
    import mmbd_pkg::*;
    localparam logic [9:0] HI = 10'h200, SI = 10'h100, FJ = 10'h080, FC = 10'h040, SJ = 10'h020;
    localparam logic [9:0] SC = 10'h010, RP = 10'h008, RL = 10'h004, RI = 10'h002, FN = 10'h001;
    logic mclk, reset;
    int fails, n_checks, cycles;
    wire logic ce, dm_rd, dm_wr, aux_rd, aux_wr, phys_rd, phys_wr, phys_sfr, own_hit;
    wire logic aux_rd_out, aux_wr_out, aux_unassigned;
    wire logic [9:0] ctl;
    wire logic [7:0] short_target, dm_wdata, phys_wdata, own_rdata;
    wire logic [11:0] far_target, pc;
    wire logic [6:0] dm_addr, phys_addr;
    wire logic [4:0] aux_addr, aux_addr_out;
    wire logic [1:0] bank_selector, phys_bank;
    wire mmbd_aux_e aux_page, aux_page_out;
    mmbd_core_model core (.mclk(mclk), .ce(ce), .ctl(ctl), .short_target(short_target),
        .far_target(far_target), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
        .aux_rd(aux_rd), .aux_wr(aux_wr), .aux_page(aux_page), .aux_addr(aux_addr));
    mmbd_top #(.STACK_DEPTH(8)) dut (.mclk(mclk), .reset(reset), .ce(ce), .fetch_next(ctl[0]),
        .short_jump(ctl[5]), .short_call(ctl[4]), .short_target(short_target), .far_jump(ctl[7]),
        .far_call(ctl[6]), .far_target(far_target), .return_plain(ctl[3]), .return_with_literal(ctl[2]),
        .return_from_interrupt(ctl[1]), .soft_int(ctl[8]), .hard_int(ctl[9]), .dm_rd(dm_rd), .dm_wr(dm_wr),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .aux_rd(aux_rd), .aux_wr(aux_wr), .aux_page(aux_page),
        .aux_addr(aux_addr), .pc(pc), .bank_selector(bank_selector), .phys_rd(phys_rd), .phys_wr(phys_wr),
        .phys_sfr(phys_sfr), .phys_bank(phys_bank), .phys_addr(phys_addr), .phys_wdata(phys_wdata),
        .own_hit(own_hit), .own_rdata(own_rdata), .aux_rd_out(aux_rd_out), .aux_wr_out(aux_wr_out),
        .aux_page_out(aux_page_out), .aux_addr_out(aux_addr_out), .aux_unassigned(aux_unassigned));
    // clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic t_program();
        check("pc_reset", pc, 12'h000);
        core.op(FC, 12'h7a3, 8'h00);
        check("far_call", pc, 12'h7a3);
        core.op(RP, 12'h000, 8'h00);
        check("ret_plain", pc, 12'h001);
        core.op(FJ, 12'hffd, 8'h00);
        check("far_top", pc, 12'hffd);
        core.op(FJ, 12'h00e, 8'h00);
        core.op(FN, 12'h000, 8'h00);
        check("roll_word", pc, 12'h00f);
        core.op(FJ, 12'h5e0, 8'h00);
        core.op(SJ, 12'h000, 8'h12);
        check("short_jump", pc, 12'h512);
        core.op(SC, 12'h000, 8'hff);
        check("short_call", pc, 12'h5ff);
        core.op(RL, 12'h000, 8'h00);
        check("ret_lit", pc, 12'h513);
        core.op(SI, 12'h000, 8'h00);
        check("soft_vec", pc, 12'h001);
        core.op(HI | SI, 12'h000, 8'h00);
        check("hard_vec", pc, 12'h008);
        core.op(RI, 12'h000, 8'h00);
        check("reti_in", pc, 12'h001);
        core.op(RI, 12'h000, 8'h00);
        check("reti_out", pc, 12'h513);
        core.ce = 1'b0;
        core.op(FN, 12'h000, 8'h00);
        check("ce_hold", pc, 12'h513);
        core.ce = 1'b1;
        core.op('0, 12'h000, 8'h00);
        core.dm(1'b0, 1'b1, ADDR_PROGRAM_COUNTER_HIGH_BUFFER, 8'h0c);
        core.dm(1'b0, 1'b1, ADDR_PCL, 8'h34);
        check("pcl_wr", pc, 12'hc34);
        check("phys_wr", {phys_wr, phys_sfr, phys_wdata}, {2'b11, 8'h34});
    endtask
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            core.dm(1'b0, 1'b1, ADDR_STATUS, {b[1:0], 6'h00});
            check("bank", {10'h0, bank_selector}, {10'h0, b[1:0]});
            core.dm(1'b1, 1'b0, 7'h10, 8'h00);
            check("sfr", {phys_rd, phys_sfr, phys_bank, phys_addr}, {2'b11, 2'b00, 7'h10});
            core.dm(1'b1, 1'b0, ADDR_STATUS, 8'h00);
            check("own", {own_hit, own_rdata}, {1'b1, b[1:0], 6'h00});
            core.dm(1'b1, 1'b0, 7'h25, 8'h00);
            check("alias", {phys_sfr, phys_bank, phys_addr}, {1'b0, 2'b00, 7'h25});
            core.dm(1'b1, 1'b0, 7'h50, 8'h00);
            check("banked", {phys_sfr, phys_bank, phys_addr}, {1'b0, b[1:0], 7'h50});
            core.dm(1'b0, 1'b1, ADDR_FSP, 8'hd5);
            core.dm(1'b1, 1'b0, ADDR_INDIRECT, 8'h00);
            check("indirect", {phys_bank, phys_addr}, {b[1:0], 7'h55});
        end
    endtask
    task automatic t_aux();
        logic [31:0] m;
        for (int p = 0; p < 3; p++) begin
            m = (p == 0) ? AUX_ONE_MAP : (p == 1) ? AUX_TWO_MAP : AUX_THREE_MAP;
            for (int a = 0; a < 32; a++) begin
                core.aux(1'b1, 1'b0, mmbd_aux_e'(p), a[4:0]);
                check("aux_rd", {aux_rd_out, aux_unassigned, aux_page_out, aux_addr_out},
                      {m[a], !m[a], p[1:0], a[4:0]});
                core.aux(1'b0, 1'b1, mmbd_aux_e'(p), a[4:0]);
                check("aux_wr", {aux_wr_out, aux_rd_out, aux_unassigned}, {m[a], 1'b0, !m[a]});
            end
        end
    endtask
    // reset, then the scenarios in turn
    initial begin
        fails = 0;
        n_checks = 0;
        cycles = 0;
        reset = 1'b1;
        repeat (12) @(posedge mclk);
        #1 reset = 1'b0;
        @(posedge mclk);
        #1;
        t_program();
        t_banks();
        t_aux();
        end_of_test();
    end
endmodule
`default_nettype wire
